// file: src/ptb_pkg.sv
// Package: register map, field positions and timing constants for throttle/break control
`default_nettype none
package ptb_pkg;
	// I/O register offsets
	localparam logic [7:0] OFS_PM_CTRL = 8'h04;
	localparam logic [7:0] OFS_EVENT_ROUTE = 8'h0e;
	localparam logic [7:0] OFS_PROC_CTRL = 8'h10;
	localparam logic [7:0] OFS_LEVEL2 = 8'h14;
	localparam logic [7:0] OFS_LEVEL3 = 8'h15;
	localparam logic [7:0] OFS_GLOBAL_EN = 8'h20;
	localparam logic [7:0] OFS_CLK_CTRL = 8'h28;
	// Field positions
	localparam int B_IRQ_EN = 0;
	localparam int B_THERM_EN = 0;
	localparam int B_USB_EN = 8;
	localparam int B_GP_INPUT_EN = 9;
	localparam int B_RING_EN = 10;
	localparam int B_LID_EN = 11;
	localparam int B_DUTY_LO = 1;
	localparam int B_THR_EN = 4;
	localparam int B_THERM_BK = 2;
	localparam int B_CLK_CTRL_EN = 0;
	localparam int B_BURST_EN = 1;
	localparam int B_SLEEP_EN = 2;
	localparam int B_STOP_STATE_EN = 3;
	// Writable masks and reset values
	localparam logic [15:0] MASK_EVENT_ROUTE = 16'h0f01;
	localparam logic [15:0] MASK_PROC_CTRL = 16'h001e;
	localparam logic [15:0] MASK_GLOBAL_EN = 16'h0004;
	localparam logic [15:0] MASK_CLK_CTRL = 16'h000f;
	localparam logic [15:0] MASK_PM_CTRL = 16'h0001;
	localparam logic [15:0] RESET_REG = 16'h0000;
	// Device variants
	localparam logic [1:0] VAR_ORIGINAL = 2'h0;
	localparam logic [1:0] VAR_ENHANCED = 2'h1;
	localparam logic [1:0] VAR_MOBILE = 2'h2;
	// Timing
	localparam int CLK_MHZ = 250;
	localparam int THR_SLOTS = 8;
	localparam int THR_PERIOD_US = 244;
	localparam int THR_PERIOD_MOBILE_NS = 30500;
	localparam int MOBILE_SLOT_CYC = (THR_PERIOD_MOBILE_NS * CLK_MHZ / 1000) / THR_SLOTS;
	localparam int THERM_HOLD_S = 2;
	localparam int TICK_HZ = 32768;
	localparam int THERM_HOLD_TICKS = THERM_HOLD_S * TICK_HZ;
	localparam logic [3:0] BURST_TICKS = 4'h8;
	// Clock control states
	typedef enum logic [1:0] {
		CC_FULL = 2'b00,
		CC_GRANT = 2'b01,
		CC_THROT = 2'b10,
		CC_BURST = 2'b11
	} ptb_state_t;
endpackage
`default_nettype wire

// file: src/ptb_throttle_break_ctrl.sv
// Processor stop-clock throttling, break/burst handling and event routing
`default_nettype none
module ptb_throttle_break_ctrl #(
	parameter logic [1:0] VARIANT = ptb_pkg::VAR_ENHANCED,
	parameter int THERM_TICKS = ptb_pkg::THERM_HOLD_TICKS
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic tick_32k,
	input wire logic [7:0] io_addr,
	input wire logic io_wr,
	input wire logic io_rd,
	input wire logic [15:0] io_wdata,
	output logic [15:0] io_rdata,
	input wire logic wake_event,
	input wire logic thermal_alarm_in_n,
	input wire logic ring_event_flag,
	input wire logic usb_event_flag,
	input wire logic lid_event_flag,
	input wire logic gp_input_event_flag,
	input wire logic thermal_event_flag,
	output logic stop_clock_out_n,
	output logic cache_sleep_out,
	output logic sys_ctrl_irq,
	output logic sys_mgmt_irq_n,
	output logic resume_event,
	output logic [1:0] cc_state
);
	import ptb_pkg::*;

	logic [15:0] pm_ctrl_q, event_route_enable_q, processor_control_q, global_event_enable_q, clk_ctrl_q;
	ptb_state_t state_q, state_d, ret_q;
	logic [2:0] slot_q;
	logic [9:0] sub_q;
	logic [16:0] therm_cnt_q;
	logic therm_ovr_q, alarm_prev_q;
	logic [3:0] burst_cnt_q;
	logic [15:0] rdata_q;
	logic stop_q, sleep_q, ctrl_irq_q, mgmt_irq_q, resume_q;

	// Register decode
	wire sel_pm = io_addr == OFS_PM_CTRL;
	wire sel_route = io_addr == OFS_EVENT_ROUTE;
	wire sel_proc = io_addr == OFS_PROC_CTRL;
	wire sel_glob = io_addr == OFS_GLOBAL_EN;
	wire sel_clk = io_addr == OFS_CLK_CTRL;
	wire level2_rd = io_rd && (io_addr == OFS_LEVEL2);
	wire level3_rd = io_rd && (io_addr == OFS_LEVEL3);

	// Control fields
	wire enhanced = VARIANT != VAR_ORIGINAL;
	wire mobile = VARIANT == VAR_MOBILE;
	wire clock_ctrl_enable = clk_ctrl_q[B_CLK_CTRL_EN];
	wire burst_enable = clk_ctrl_q[B_BURST_EN];
	wire cache_sleep_enable = clk_ctrl_q[B_SLEEP_EN];
	wire throttle_enable = processor_control_q[B_THR_EN];
	wire [2:0] throttle_duty_field = processor_control_q[B_DUTY_LO +: 3];
	wire thermal_break_enable = global_event_enable_q[B_THERM_BK];
	wire sys_ctrl_irq_enable = pm_ctrl_q[B_IRQ_EN];

	// Register writes
	// enables reset to zero
	always_ff @(posedge clk) begin
		if (reset) begin
			pm_ctrl_q <= RESET_REG;
			event_route_enable_q <= RESET_REG;
			processor_control_q <= RESET_REG;
			global_event_enable_q <= RESET_REG;
			clk_ctrl_q <= RESET_REG;
		end else if (io_wr) begin
			if (sel_pm) pm_ctrl_q <= io_wdata & MASK_PM_CTRL;
			if (sel_route) event_route_enable_q <= io_wdata & MASK_EVENT_ROUTE;
			if (sel_proc) processor_control_q <= io_wdata & MASK_PROC_CTRL;
			if (sel_glob) global_event_enable_q <= io_wdata & MASK_GLOBAL_EN;
			if (sel_clk) clk_ctrl_q <= io_wdata & MASK_CLK_CTRL;
		end
	end

	// Read data, one cycle after the strobe; unmapped reads zero
	wire [15:0] rd_mux = sel_pm ? pm_ctrl_q : sel_route ? event_route_enable_q :
		sel_proc ? processor_control_q : sel_glob ? global_event_enable_q :
		sel_clk ? clk_ctrl_q : 16'h0000;
	always_ff @(posedge clk) begin
		if (reset) rdata_q <= 16'h0000;
		else if (io_rd) rdata_q <= rd_mux;
	end
	assign io_rdata = rdata_q;

	// Throttle slot timing: eighths of a period
	// standard period is eight 32 kHz ticks
	// mobile eighth counted in core cycles
	wire sub_wrap = sub_q == 10'(MOBILE_SLOT_CYC - 1);
	wire slot_adv = mobile ? sub_wrap : tick_32k;
	always_ff @(posedge clk) begin
		if (reset) begin
			sub_q <= 10'h000;
			slot_q <= 3'h0;
		end else begin
			sub_q <= sub_wrap ? 10'h000 : sub_q + 10'h001;
			if (slot_adv) slot_q <= slot_q + 3'h1;
		end
	end
	// assert for 8 minus code eighths; 000 never
	wire duty_on = (throttle_duty_field != 3'h0) && ({1'b0, slot_q} < (4'h8 - {1'b0, throttle_duty_field}));

	// Thermal alarm hold timer
	// alarm held beyond 2 s in low power
	wire low_power = state_q != CC_FULL;
	wire alarm = !thermal_alarm_in_n;
	wire therm_release = therm_ovr_q && !alarm;
	always_ff @(posedge clk) begin
		if (reset) begin
			therm_cnt_q <= 17'h00000;
			therm_ovr_q <= 1'b0;
			alarm_prev_q <= 1'b0;
		end else begin
			alarm_prev_q <= alarm;
			if (!alarm) therm_cnt_q <= 17'h00000;
			else if (low_power && tick_32k && therm_cnt_q != 17'(THERM_TICKS)) therm_cnt_q <= therm_cnt_q + 17'h00001;
			if (!alarm) therm_ovr_q <= 1'b0;
			else if (therm_cnt_q == 17'(THERM_TICKS) && low_power) therm_ovr_q <= 1'b1;
		end
	end

	// Break sources
	// thermal release can break on enhanced parts
	wire therm_brk = therm_release && thermal_break_enable;
	wire brk_raw = wake_event || therm_brk;
	wire brk = brk_raw && (enhanced || !therm_ovr_q);
	// burst enable splits the event kind
	wire stop_brk = brk && !burst_enable;
	wire burst_ev = brk && burst_enable;
	wire manual = enhanced && clock_ctrl_enable && throttle_enable;
	wire burst_done = burst_cnt_q == BURST_TICKS;

	// Clock control state machine
	always_comb begin
		state_d = state_q;
		case (state_q)
			CC_FULL: begin
				if (clock_ctrl_enable && level2_rd && throttle_enable && !enhanced) state_d = CC_THROT;
				else if (clock_ctrl_enable && (level2_rd || level3_rd)) state_d = CC_GRANT;
				else if (manual) state_d = CC_THROT;
			end
			CC_GRANT: begin
				if (!clock_ctrl_enable) state_d = CC_FULL;
				else if (stop_brk) state_d = manual ? CC_THROT : CC_FULL;
				else if (burst_ev) state_d = CC_BURST;
			end
			CC_THROT: begin
				if (!clock_ctrl_enable || (enhanced && !throttle_enable)) state_d = CC_FULL;
				// level-2 read drops to plain grant
				else if (enhanced && level2_rd) state_d = CC_GRANT;
				else if (!enhanced && stop_brk) state_d = CC_FULL;
				else if (!enhanced && burst_ev) state_d = CC_BURST;
			end
			default: begin
				if (!clock_ctrl_enable) state_d = CC_FULL;
				else if (stop_brk) state_d = CC_FULL;
				else if (burst_done) state_d = ret_q;
			end
		endcase
	end

	// State, burst return point and burst timer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= CC_FULL;
			ret_q <= CC_FULL;
			burst_cnt_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (state_q != CC_BURST) ret_q <= state_q;
			if (state_q != CC_BURST) burst_cnt_q <= 4'h0;
			else if (tick_32k && !burst_done) burst_cnt_q <= burst_cnt_q + 4'h1;
		end
	end
	assign cc_state = state_q;

	// Stop clock and cache sleep drive
	// toggling while throttling; thermal forces it on enhanced parts
	wire throttling = (state_q == CC_THROT) || (enhanced && therm_ovr_q);
	wire stop_d = (state_q == CC_GRANT && !(enhanced && therm_ovr_q)) || (throttling && duty_on);
	always_ff @(posedge clk) begin
		if (reset) begin
			stop_q <= 1'b0;
			sleep_q <= 1'b0;
		end else begin
			stop_q <= stop_d;
			sleep_q <= cache_sleep_enable && throttling && duty_on;
		end
	end
	assign stop_clock_out_n = !stop_q;
	assign cache_sleep_out = sleep_q;

	// Event routing to interrupts and resume
	// ring and USB only through the control irq
	wire ring_hit = ring_event_flag && event_route_enable_q[B_RING_EN];
	wire usb_hit = usb_event_flag && event_route_enable_q[B_USB_EN];
	// lid, input and thermal routed by mode
	wire lid_hit = lid_event_flag && event_route_enable_q[B_LID_EN];
	wire gpi_hit = gp_input_event_flag && event_route_enable_q[B_GP_INPUT_EN];
	wire therm_hit = thermal_event_flag && event_route_enable_q[B_THERM_EN];
	wire mgmt_src = lid_hit || gpi_hit || therm_hit;
	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_irq_q <= 1'b0;
			mgmt_irq_q <= 1'b0;
			resume_q <= 1'b0;
		end else begin
			ctrl_irq_q <= sys_ctrl_irq_enable && (ring_hit || usb_hit || mgmt_src);
			mgmt_irq_q <= !sys_ctrl_irq_enable && mgmt_src;
			resume_q <= ring_hit || usb_hit || lid_hit || gpi_hit;
		end
	end
	assign sys_ctrl_irq = ctrl_irq_q;
	assign sys_mgmt_irq_n = !mgmt_irq_q;
	assign resume_event = resume_q;

	// Checks
	AST_CC_CLEAR: assert property (@(posedge clk) disable iff (reset)
		!clock_ctrl_enable && state_q != CC_FULL |=> state_q == CC_FULL)
		else $error("clock control left on after enable cleared");
	AST_MANUAL_START: assert property (@(posedge clk) disable iff (reset)
		enhanced && state_q == CC_FULL && manual && !level2_rd && !level3_rd |=> state_q == CC_THROT)
		else $error("manual throttle did not start");
	AST_MANUAL_STOP: assert property (@(posedge clk) disable iff (reset)
		enhanced && state_q == CC_THROT && !throttle_enable |=> state_q == CC_FULL)
		else $error("manual throttle did not stop");
	AST_ORIG_BREAK: assert property (@(posedge clk) disable iff (reset)
		!enhanced && state_q == CC_THROT && clock_ctrl_enable && stop_brk |=> state_q == CC_FULL)
		else $error("break did not end throttling");
	AST_ENH_HOLD: assert property (@(posedge clk) disable iff (reset)
		enhanced && state_q == CC_THROT && manual && !level2_rd |=> state_q == CC_THROT)
		else $error("throttle ended while enabled");
	AST_GRANT_BREAK: assert property (@(posedge clk) disable iff (reset)
		enhanced && state_q == CC_GRANT && manual && stop_brk |=> state_q == CC_THROT)
		else $error("no throttle after break from grant");
	AST_DUTY: assert property (@(posedge clk) disable iff (reset)
		state_q == CC_THROT && !therm_ovr_q && throttle_duty_field == 3'h7 && slot_q == 3'h1 && $stable(state_q)
		|=> stop_clock_out_n)
		else $error("12.5 percent duty asserted too long");
	AST_GRANT_STOP: assert property (@(posedge clk) disable iff (reset)
		state_q == CC_GRANT && !therm_ovr_q |=> !stop_clock_out_n)
		else $error("stop clock not asserted in grant");
	AST_RING_IRQ: assert property (@(posedge clk) disable iff (reset)
		ring_event_flag && !(sys_ctrl_irq_enable && event_route_enable_q[B_RING_EN]) && !usb_hit && !mgmt_src
		|=> !sys_ctrl_irq)
		else $error("ring irq without both enables");
	AST_THERM_DEFER: assert property (@(posedge clk) disable iff (reset)
		!enhanced && therm_ovr_q && state_q == CC_GRANT && clock_ctrl_enable |=> state_q != CC_FULL)
		else $error("break not deferred under thermal override");
	AST_THERM_BREAK: assert property (@(posedge clk) disable iff (reset)
		enhanced && therm_ovr_q && alarm_prev_q && !alarm && thermal_break_enable && !burst_enable
		&& state_q == CC_GRANT && clock_ctrl_enable && !manual |=> state_q == CC_FULL)
		else $error("thermal release produced no break");
	AST_ENH_LEVEL2: assert property (@(posedge clk) disable iff (reset)
		enhanced && state_q != CC_BURST && manual && level2_rd && !brk |=> state_q == CC_GRANT)
		else $error("level-2 read did not enter grant");
	AST_BURST_KIND: assert property (@(posedge clk) disable iff (reset)
		state_q == CC_GRANT && clock_ctrl_enable && burst_enable && brk |=> state_q == CC_BURST)
		else $error("wake with burst enable did not burst");
	AST_USB_IRQ: assert property (@(posedge clk) disable iff (reset)
		usb_event_flag && !(sys_ctrl_irq_enable && event_route_enable_q[B_USB_EN]) && !ring_hit && !mgmt_src
		|=> !sys_ctrl_irq)
		else $error("usb irq without both enables");
	AST_THERM_THROTTLE: assert property (@(posedge clk) disable iff (reset)
		enhanced && therm_ovr_q && state_q == CC_GRANT && !duty_on |=> stop_clock_out_n)
		else $error("thermal override did not release stop clock");
	AST_ZERO_DUTY: assert property (@(posedge clk) disable iff (reset)
		state_q == CC_THROT && throttle_duty_field == 3'h0 |=> stop_clock_out_n)
		else $error("reserved duty code asserted stop clock");

	COV_THROTTLE: cover property (@(posedge clk) disable iff (reset) state_q == CC_FULL ##1 state_q == CC_THROT);
	COV_BURST: cover property (@(posedge clk) disable iff (reset) state_q == CC_BURST ##1 state_q == CC_GRANT);
	COV_THERM: cover property (@(posedge clk) disable iff (reset) $rose(therm_ovr_q));
	COV_CTRL_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(sys_ctrl_irq));
endmodule
`default_nettype wire

// file: verification/processor_throttle_break_control_tb.sv
// Testbench for throttle, break and event routing control
`default_nettype none
module processor_throttle_break_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import ptb_pkg::*;
	typedef struct packed {logic [15:0] pm; logic [15:0] rt; logic [4:0] fl; logic cirq; logic mirq_n; logic res;} ptb_row_t;
	localparam int T = 4;
	logic clk = 0, reset = 1, tick_32k = 0, io_wr = 0, io_rd = 0, wake_event = 0, thermal_alarm_in_n = 1;
	logic [7:0] io_addr = 0;
	logic [15:0] io_wdata = 0, rd_q;
	logic [4:0] fl = 0;
	logic [1:0] tc = 0;
	logic ring_event_flag, usb_event_flag, lid_event_flag, gp_input_event_flag, thermal_event_flag;
	wire logic [15:0] io_rdata;
	wire logic stop_n, sleep, cirq, mirq_n, res, mob_n;
	wire logic [1:0] st, st_org;
	int fails = 0, checks_done = 0, stop_cnt, sleep_cnt, mob_cnt, a, b, i, d, k, s, z;
	logic [7:0] ra [6] = '{8'h04, 8'h0e, 8'h10, 8'h20, 8'h28, 8'h30};
	logic [15:0] rm [6] = '{16'h0001, 16'h0f01, 16'h001e, 16'h0004, 16'h000f, 16'h0000};
	ptb_row_t rows [12] = '{'{16'h1, 16'h0400, 5'h10, 1'b1, 1'b1, 1'b1}, '{16'h0, 16'h0400, 5'h10, 1'b0, 1'b1, 1'b1},
		'{16'h1, 16'h0000, 5'h10, 1'b0, 1'b1, 1'b0}, '{16'h1, 16'h0100, 5'h08, 1'b1, 1'b1, 1'b1},
		'{16'h1, 16'h0e01, 5'h08, 1'b0, 1'b1, 1'b0}, '{16'h1, 16'h0800, 5'h04, 1'b1, 1'b1, 1'b1},
		'{16'h0, 16'h0800, 5'h04, 1'b0, 1'b0, 1'b1}, '{16'h1, 16'h0200, 5'h02, 1'b1, 1'b1, 1'b1},
		'{16'h0, 16'h0200, 5'h02, 1'b0, 1'b0, 1'b1}, '{16'h1, 16'h0001, 5'h01, 1'b1, 1'b1, 1'b0},
		'{16'h0, 16'h0001, 5'h01, 1'b0, 1'b0, 1'b0}, '{16'h1, 16'h00fe, 5'h01, 1'b0, 1'b1, 1'b0}};
	assign {ring_event_flag, usb_event_flag, lid_event_flag, gp_input_event_flag, thermal_event_flag} = fl;
	// Enhanced, original and mobile parts share the bus
	ptb_throttle_break_ctrl #(.THERM_TICKS(4)) u_dut (.clk, .reset, .tick_32k, .io_addr, .io_wr, .io_rd,
		.io_wdata, .io_rdata, .wake_event, .thermal_alarm_in_n, .ring_event_flag, .usb_event_flag,
		.lid_event_flag, .gp_input_event_flag, .thermal_event_flag, .stop_clock_out_n(stop_n),
		.cache_sleep_out(sleep), .sys_ctrl_irq(cirq), .sys_mgmt_irq_n(mirq_n), .resume_event(res), .cc_state(st));
	ptb_throttle_break_ctrl #(.VARIANT(VAR_ORIGINAL), .THERM_TICKS(4)) u_org (.clk, .reset, .tick_32k,
		.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata(), .wake_event, .thermal_alarm_in_n, .ring_event_flag,
		.usb_event_flag, .lid_event_flag, .gp_input_event_flag, .thermal_event_flag, .stop_clock_out_n(),
		.cache_sleep_out(), .sys_ctrl_irq(), .sys_mgmt_irq_n(), .resume_event(), .cc_state(st_org));
	ptb_throttle_break_ctrl #(.VARIANT(VAR_MOBILE), .THERM_TICKS(4)) u_mob (.clk, .reset, .tick_32k,
		.io_addr, .io_wr, .io_rd, .io_wdata, .io_rdata(), .wake_event, .thermal_alarm_in_n, .ring_event_flag,
		.usb_event_flag, .lid_event_flag, .gp_input_event_flag, .thermal_event_flag, .stop_clock_out_n(mob_n),
		.cache_sleep_out(), .sys_ctrl_irq(), .sys_mgmt_irq_n(), .resume_event(), .cc_state());
	ptb_host_model p_dut (.clk(clk), .reset(reset), .stop_clock_out_n(stop_n), .cache_sleep_out(sleep),
		.stop_cnt(stop_cnt), .sleep_cnt(sleep_cnt));
	ptb_host_model p_mob (.clk(clk), .reset(reset), .stop_clock_out_n(mob_n), .cache_sleep_out(1'b0),
		.stop_cnt(mob_cnt), .sleep_cnt());
	// Clock and a slow tick every T cycles
	always #2 clk = ~clk;
	always @(posedge clk) begin
		#1;
		tc = tc + 2'h1;
		tick_32k = (tc == 2'h0);
	end
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task wr(input logic [7:0] ad, input logic [15:0] dat);
		cyc(1);
		io_addr = ad;
		io_wdata = dat;
		io_wr = 1;
		cyc(1);
		io_wr = 0;
	endtask
	task rd(input logic [7:0] ad);
		cyc(1);
		io_addr = ad;
		io_rd = 1;
		cyc(1);
		io_rd = 0;
		cyc(1);
		rd_q = io_rdata;
	endtask
	task wake();
		cyc(1);
		wake_event = 1;
		cyc(1);
		wake_event = 0;
	endtask
	task meas(input int n);
		a = stop_cnt;
		b = sleep_cnt;
		cyc(n);
		s = stop_cnt - a;
		z = sleep_cnt - b;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task done(input string nm);
		$display("test %s done", nm);
	endtask
	task complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// Watchdog well beyond the expected run
	initial begin
		#320000;
		fails++;
		complete_run();
	end
	// Main sequence
	initial begin
		cyc(12);
		reset = 0;
		chk("stop", 1, stop_n);
		chk("state", CC_FULL, st);
		for (i = 0; i < 6; i++) begin
			rd(ra[i]);
			chk("reset value", 0, rd_q);
			wr(ra[i], 16'hffff);
			rd(ra[i]);
			chk("writable", rm[i], rd_q);
			wr(ra[i], 16'h0000);
		end
		done("registers");
		foreach (rows[i]) begin
			wr(8'h04, rows[i].pm);
			wr(8'h0e, rows[i].rt);
			fl = rows[i].fl;
			cyc(3);
			chk("ctrl irq", rows[i].cirq, cirq);
			chk("mgmt irq", rows[i].mirq_n, mirq_n);
			chk("resume", rows[i].res, res);
			fl = 5'h00;
		end
		wr(8'h04, 16'h0000);
		wr(8'h0e, 16'h0000);
		done("events");
		wr(8'h28, 16'h0005);
		for (d = 0; d < 8; d++) begin
			wr(8'h10, 16'h0010 | 16'(d * 2));
			cyc(100);
			meas(8 * T);
			chk("low", d ? (8 - d) * T : 0, s);
			chk("sleep", d ? (8 - d) * T : 0, z);
			chk("original", CC_FULL, st_org);
			if (d == 4) begin
				cyc(16 * MOBILE_SLOT_CYC);
				a = mob_cnt;
				cyc(8 * MOBILE_SLOT_CYC);
				chk("mobile", 4 * MOBILE_SLOT_CYC, mob_cnt - a);
			end
		end
		done("duty");
		wr(8'h10, 16'h0018);
		rd(8'h14);
		cyc(2);
		chk("state", CC_GRANT, st);
		meas(8 * T);
		chk("low", 8 * T, s);
		chk("original", CC_THROT, st_org);
		wake();
		cyc(3);
		chk("state", CC_THROT, st);
		chk("original", CC_FULL, st_org);
		wake();
		cyc(3);
		chk("state", CC_THROT, st);
		wr(8'h10, 16'h0008);
		cyc(3);
		chk("state", CC_FULL, st);
		meas(8 * T);
		chk("low", 0, s);
		done("throttle");
		wr(8'h28, 16'h0003);
		rd(8'h14);
		wake();
		cyc(1);
		chk("state", CC_BURST, st);
		cyc(40);
		chk("state", CC_GRANT, st);
		wr(8'h28, 16'h0001);
		wake();
		cyc(1);
		chk("state", CC_FULL, st);
		rd(8'h15);
		cyc(1);
		chk("state", CC_GRANT, st);
		wr(8'h28, 16'h0000);
		cyc(2);
		chk("state", CC_FULL, st);
		chk("stop", 1, stop_n);
		rd(8'h14);
		cyc(1);
		chk("state", CC_FULL, st);
		done("break");
		wr(8'h28, 16'h0001);
		rd(8'h14);
		for (k = 0; k < 3; k++) begin
			wr(8'h20, (k == 1) ? 16'h0004 : 16'h0000);
			if (k == 2) rd(8'h14);
			thermal_alarm_in_n = 0;
			cyc(7 * T);
			chk("state", CC_GRANT, st);
			meas(8 * T);
			chk("low", 4 * T, s);
			if (k == 2) begin
				wake();
				cyc(2);
				chk("state", CC_FULL, st);
				chk("original", CC_GRANT, st_org);
			end
			thermal_alarm_in_n = 1;
			cyc(8);
			chk("state", k ? CC_FULL : CC_GRANT, st);
		end
		done("thermal");
		wr(8'h10, 16'h0018);
		wr(8'h28, 16'h0001);
		cyc(20);
		reset = 1;
		cyc(2);
		chk("stop", 1, stop_n);
		chk("state", CC_FULL, st);
		cyc(10);
		reset = 0;
		rd(8'h10);
		chk("control", 0, rd_q);
		done("reset");
		complete_run();
	end
endmodule
`default_nettype wire

// file: verification/ptb_host_model.sv
// Host processor model counting stop-clock and cache-sleep time
`default_nettype none
module ptb_host_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic stop_clock_out_n,
	input wire logic cache_sleep_out,
	output var int stop_cnt,
	output var int sleep_cnt
);
	timeunit 1ns;
	timeprecision 1ps;
	always @(posedge clk) begin
		if (reset) begin
			stop_cnt <= 0;
			sleep_cnt <= 0;
		end else begin
			stop_cnt <= stop_cnt + (stop_clock_out_n ? 0 : 1);
			sleep_cnt <= sleep_cnt + (cache_sleep_out ? 1 : 0);
		end
	end
endmodule
`default_nettype wire
